// file: stt_pkg.sv
// Constants and types shared by the string translate-and-test sequencer
package stt_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;

  // ****************************************************************
  // Timing, in processor cycles (one processor cycle = one clk_sys cycle)
  // ****************************************************************
  localparam int SETUP_CYCLES = 11;
  localparam int ELEM_CYCLES = 14;
  localparam int SINGLE_CYCLES = 25;
  localparam int INTR_CYCLES = 7;
  localparam int TIMER_W = 5;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [ADDR_W-1:0] PTR_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] BYTE_RESET = 8'h00;

  // ****************************************************************
  // Operations
  // ****************************************************************
  typedef enum logic [1:0] {
    STT_SCAN_DECREMENT_SINGLE_OP = 2'h0,
    STT_SCAN_DECREMENT_REPEAT_OP = 2'h1,
    STT_TRANSLATE_INCREMENT_REPEAT_OP = 2'h2
  } stt_op_e;

  // Gray coded along setup, target, table, write, pad, interrupt, done
  typedef enum logic [3:0] {
    STT_IDLE = 4'h0,
    STT_SETUP = 4'h1,
    STT_TARGET = 4'h3,
    STT_TABLE = 4'h7,
    STT_WRITE = 4'h6,
    STT_PAD = 4'h4,
    STT_INTR = 4'hc,
    STT_DONE = 4'h8
  } stt_state_e;

endpackage

// file: stt_string_translate_test_unit.sv
// Sequencer for byte-string translate-and-test instructions
`timescale 1ns/10ps

// How it works
// - After translate-increment-repeat, high byte result holds the last fetched table byte.
// - Repeating forms may be interrupted between steps; instruction start PC reported.
// - Each accepted interrupt adds seven cycles before the instruction stops.
// - Target byte read at first pointer; indexes table based at second pointer.
// - Table address is base plus zero-extended target, wrapping like address arithmetic.
// - Fetched table byte loads into the high byte result register.
// - Test forms set zero flag when table byte is zero, else clear it.
// - Test forms never write memory.
// - Decrementing forms reduce first pointer by one; table base unchanged.
// - Counter word decremented by one after every step.
// - Overflow flag set when decremented counter is zero, else cleared.
// - Repeating scan stops on non-zero table byte or counter reaching zero.
// - Repeating forms handle 1 to 65536 elements via 16-bit counter.
module stt_string_translate_test_unit #(
  parameter int ADDR_W = stt_pkg::ADDR_W,
  parameter int CNT_W = stt_pkg::CNT_W
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic start,
  input wire stt_pkg::stt_op_e opSel,
  input wire logic [ADDR_W-1:0] ptrIn,
  input wire logic [ADDR_W-1:0] baseIn,
  input wire logic [CNT_W-1:0] countIn,
  input wire logic [ADDR_W-1:0] pcIn,
  input wire logic irqPending,
  output logic busy,
  output logic done,
  output logic intTaken,
  output logic [ADDR_W-1:0] savedPc,
  output logic [ADDR_W-1:0] ptrOut,
  output logic [ADDR_W-1:0] baseOut,
  output logic [CNT_W-1:0] countOut,
  output logic [stt_pkg::DATA_W-1:0] highByteResult,
  output logic zeroFlag,
  output logic overflowFlag,
  output logic flagWrite,
  output logic memReq,
  output logic memWe,
  output logic [ADDR_W-1:0] memAddr,
  output logic [stt_pkg::DATA_W-1:0] memWrData,
  input wire logic memAck,
  input wire logic [stt_pkg::DATA_W-1:0] memRdData
);
  import stt_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  stt_state_e state;
  stt_op_e op;
  logic [TIMER_W-1:0] timer;
  logic [ADDR_W-1:0] startPc;
  logic [DATA_W-1:0] tableVal;

  logic stepEnd;
  logic [ADDR_W-1:0] next_ptr;
  logic [CNT_W-1:0] next_count;
  logic stopScan;

  function automatic logic isScan(input stt_op_e o);
    isScan = (o != STT_TRANSLATE_INCREMENT_REPEAT_OP);
  endfunction

  // ****************************************************************
  // Step arithmetic
  // ****************************************************************
  // Step ends once the element slot has run its full length
  assign stepEnd = (state == STT_PAD) && (timer >= TIMER_W'(ELEM_CYCLES - 1));

  always_comb begin
    if (isScan(op)) begin
      next_ptr = ptrOut - ADDR_W'(1);
    end else begin
      next_ptr = ptrOut + ADDR_W'(1);
    end
  end

  assign next_count = countOut - CNT_W'(1);

  always_comb begin
    stopScan = (next_count == '0) || (op == STT_SCAN_DECREMENT_SINGLE_OP);
    if (op == STT_SCAN_DECREMENT_REPEAT_OP && tableVal != '0) begin
      stopScan = 1'b1;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state <= STT_IDLE;
      op <= STT_SCAN_DECREMENT_SINGLE_OP;
      timer <= '0;
    end else begin
      unique case (state)
        STT_IDLE: begin
          timer <= '0;
          if (start) begin
            op <= opSel;
            state <= STT_SETUP;
          end
        end
        STT_SETUP: begin
          timer <= timer + TIMER_W'(1);
          if (timer == TIMER_W'(SETUP_CYCLES - 1)) begin
            timer <= '0;
            state <= STT_TARGET;
          end
        end
        STT_TARGET: begin
          timer <= timer + TIMER_W'(1);
          if (memAck) begin
            state <= STT_TABLE;
          end
        end
        STT_TABLE: begin
          timer <= timer + TIMER_W'(1);
          if (memAck) begin
            state <= isScan(op) ? STT_PAD : STT_WRITE;
          end
        end
        STT_WRITE: begin
          timer <= timer + TIMER_W'(1);
          if (memAck) begin
            state <= STT_PAD;
          end
        end
        STT_PAD: begin
          timer <= timer + TIMER_W'(1);
          if (stepEnd) begin
            timer <= '0;
            if (stopScan) begin
              state <= STT_DONE;
            end else if (irqPending && op != STT_SCAN_DECREMENT_SINGLE_OP) begin
              state <= STT_INTR;
            end else begin
              state <= STT_TARGET;
            end
          end
        end
        STT_INTR: begin
          timer <= timer + TIMER_W'(1);
          if (timer == TIMER_W'(INTR_CYCLES - 1)) begin
            timer <= '0;
            state <= STT_DONE;
          end
        end
        STT_DONE: begin
          state <= STT_IDLE;
        end
        default: begin
          state <= STT_IDLE;
        end
      endcase
    end
  end

  assign busy = (state != STT_IDLE);
  assign done = (state == STT_DONE);

  // ****************************************************************
  // Interrupt report
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      startPc <= PTR_RESET;
      savedPc <= PTR_RESET;
      intTaken <= 1'b0;
    end else begin
      if (state == STT_IDLE && start) begin
        startPc <= pcIn;
      end
      intTaken <= (state == STT_INTR) && (timer == TIMER_W'(INTR_CYCLES - 1));
      if (state == STT_INTR) begin
        savedPc <= startPc;
      end
    end
  end

  // ****************************************************************
  // Operand registers and flags
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ptrOut <= PTR_RESET;
      baseOut <= PTR_RESET;
      countOut <= CNT_RESET;
      zeroFlag <= 1'b0;
      overflowFlag <= 1'b0;
      flagWrite <= 1'b0;
    end else begin
      flagWrite <= 1'b0;
      if (state == STT_IDLE && start) begin
        ptrOut <= ptrIn;
        baseOut <= baseIn;
        countOut <= countIn;
      end
      if (stepEnd) begin
        ptrOut <= next_ptr;
        countOut <= next_count;
        overflowFlag <= (next_count == '0);
        zeroFlag <= (tableVal == '0);
        // only these two flags are written
        flagWrite <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Memory port
  // ****************************************************************
  // Reads and write-back use the same address/data registers so the bus
  // sees stable values for the whole of each access.
  assign memReq = (state == STT_TARGET) || (state == STT_TABLE) || (state == STT_WRITE);
  assign memWe = (state == STT_WRITE);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      memAddr <= PTR_RESET;
      memWrData <= BYTE_RESET;
      tableVal <= BYTE_RESET;
      highByteResult <= BYTE_RESET;
    end else begin
      if (state == STT_IDLE && start) begin
        // first access at the string pointer
        memAddr <= ptrIn;
      end
      if (state == STT_PAD && stepEnd) begin
        memAddr <= next_ptr;
      end
      if (state == STT_TARGET && memAck) begin
        memAddr <= baseOut + {{(ADDR_W - DATA_W){1'b0}}, memRdData};
      end
      if (state == STT_TABLE && memAck) begin
        // translate form leaves it holding the last translation
        tableVal <= memRdData;
        highByteResult <= memRdData;
        memAddr <= ptrOut;
        memWrData <= memRdData;
      end
    end
  end

endmodule

// file: stt_unit_assertions.sv
// Concurrent checks on the translate-and-test sequencer ports
`timescale 1ns/10ps
module stt_unit_assertions
  import stt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic start,
  input wire stt_pkg::stt_op_e opSel,
  input wire logic [15:0] pcIn,
  input wire logic busy,
  input wire logic done,
  input wire logic intTaken,
  input wire logic [15:0] savedPc,
  input wire logic [15:0] ptrOut,
  input wire logic [15:0] baseOut,
  input wire logic [15:0] countOut,
  input wire logic [7:0] highByteResult,
  input wire logic zeroFlag,
  input wire logic overflowFlag,
  input wire logic flagWrite,
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [15:0] memAddr,
  input wire logic memAck,
  input wire logic [7:0] memRdData
);
  stt_op_e opL;
  logic [15:0] pcL;
  logic tPh;
  int cyc;
  int stl;
  int stp;
  wire take = start && !busy;
  wire rdAck = memReq && memAck && !memWe;
  // Stall count lets timing be judged only on zero-wait runs
  always_ff @(posedge clk_sys) begin
    if (!reset_n || take) begin
      opL <= opSel;
      pcL <= pcIn;
      tPh <= 1'b0;
      cyc <= 1;
      stl <= 0;
      stp <= 0;
    end else begin
      tPh <= tPh ^ rdAck;
      cyc <= cyc + 1;
      stl <= stl + int'(memReq && !memAck);
      stp <= stp + int'(flagWrite);
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence scanEnd;
    flagWrite && opL != STT_TRANSLATE_INCREMENT_REPEAT_OP;
  endsequence
  property tblAddr;
    logic [7:0] t;
    (rdAck && !tPh, t = memRdData) |=> memAddr == baseOut + {8'h00, t};
  endproperty
  AST_NO_WR: assert property (opL != STT_TRANSLATE_INCREMENT_REPEAT_OP |-> !memWe)
    else $error("scan wrote memory");
  AST_BASE: assert property (busy && $past(busy) |-> $stable(baseOut))
    else $error("table base moved");
  AST_PTR: assert property (scanEnd |-> ptrOut == $past(ptrOut) - 16'h0001)
    else $error("pointer not decremented");
  AST_CNT: assert property (flagWrite |-> countOut == $past(countOut) - 16'h0001)
    else $error("counter not decremented");
  AST_OVF: assert property (flagWrite |-> overflowFlag == (countOut == 16'h0000))
    else $error("overflow flag wrong");
  AST_ZF: assert property (scanEnd |-> zeroFlag == (highByteResult == 8'h00))
    else $error("zero flag wrong");
  AST_TADDR: assert property (tblAddr)
    else $error("table address wrong");
  AST_TIME: assert property (
    done && !intTaken && stl == 0 |-> cyc == 12 + 14 * (stp + int'(flagWrite)))
    else $error("step timing wrong");
  AST_INT: assert property (
    intTaken |-> done && savedPc == pcL && (stl != 0 || cyc == 19 + 14 * stp))
    else $error("interrupt exit wrong");
  AST_STOP: assert property (
    flagWrite && opL == STT_SCAN_DECREMENT_REPEAT_OP && (!zeroFlag || overflowFlag)
    |-> done && !intTaken)
    else $error("scan did not stop");
endmodule
bind stt_string_translate_test_unit stt_unit_assertions i_chk (.*);

// file: stt_mem_model.sv
// Behavioural byte memory answering the sequencer's accesses
`timescale 1ns/10ps
module stt_mem_model (
  input wire logic clk_sys,
  input wire logic slow,
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [15:0] memAddr,
  input wire logic [7:0] memWrData,
  output logic memAck,
  output logic [7:0] memRdData
);
  logic [7:0] mem [65536];
  logic [7:0] lastRd = 8'h5a;
  int waitCnt = 0;
  int nWr = 0;
  assign memAck = memReq && (!slow || waitCnt == 2);
  // Outside an answer the bus shows junk, never the stale byte
  assign memRdData = memAck ? mem[memAddr] : ~lastRd;
  always @(posedge clk_sys) begin
    waitCnt <= (memReq && !memAck) ? waitCnt + 1 : 0;
    if (memAck && !memWe)
      lastRd <= mem[memAddr];
    if (memAck && memWe) begin
      mem[memAddr] <= memWrData;
      nWr <= nWr + 1;
    end
  end
endmodule

// file: tb_top.sv
// Self-checking bench for the string translate-and-test sequencer
`timescale 1ns/10ps
module tb_top;
  import stt_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic start = 1'b0;
  logic irqPending = 1'b0;
  logic slow = 1'b0;
  stt_op_e opSel = STT_SCAN_DECREMENT_SINGLE_OP;
  logic [15:0] ptrIn = 16'h0000, baseIn = 16'h0000, countIn = 16'h0000, pcIn = 16'h0abc;
  logic busy, done, intTaken, zeroFlag, overflowFlag, flagWrite, memReq, memWe, memAck;
  logic [15:0] savedPc, ptrOut, baseOut, countOut, memAddr;
  logic [7:0] highByteResult, memWrData, memRdData;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc;
  always #2.5 clk_sys = ~clk_sys;
  stt_string_translate_test_unit i_dut (.*);
  stt_mem_model i_mem (.*);
  task automatic end_sim();
    $display("Compared %0d, mismatched %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Issue one instruction and count cycles until it ends
  task automatic run(input stt_op_e op, input logic [15:0] p, b, c, input logic irq, sl);
    @(negedge clk_sys);
    opSel = op;
    {ptrIn, baseIn, countIn} = {p, b, c};
    {irqPending, slow, start} = {irq, sl, 1'b1};
    @(negedge clk_sys);
    start = 1'b0;
    cyc = 1;
    while (done !== 1'b1 && cyc < 3000) begin
      @(negedge clk_sys);
      cyc++;
    end
    if (cyc >= 3000) begin
      $display("[ERR] done expected 1 seen 0");
      n_fail++;
      end_sim();
    end
  endtask
  task automatic t_single();
    i_mem.mem[16'h4001] = 8'h03;
    i_mem.mem[16'h1003] = 8'haa;
    run(STT_SCAN_DECREMENT_SINGLE_OP, 16'h4001, 16'h1000, 16'h0002, 1'b0, 1'b0);
    chk("result", 16'h00aa, 16'(highByteResult));
    chk("ptr", 16'h4000, ptrOut);
    chk("count", 16'h0001, countOut);
    chk("flags", 16'h0000, 16'({zeroFlag, overflowFlag}));
    chk("cycles", 16'd26, 16'(cyc));
    chk("writes", 16'h0000, 16'(i_mem.nWr));
    $display("t_single finished");
  endtask
  task automatic t_repeat();
    for (int i = 0; i < 256; i++)
      i_mem.mem[16'h1000 + i] = 8'(i & 8'h7f);
    {i_mem.mem[16'h4000], i_mem.mem[16'h4001], i_mem.mem[16'h4002]} = 24'h004080;
    run(STT_SCAN_DECREMENT_REPEAT_OP, 16'h4002, 16'h1000, 16'h0003, 1'b0, 1'b1);
    chk("result", 16'h0040, 16'(highByteResult));
    chk("ptr", 16'h4000, ptrOut);
    chk("count", 16'h0001, countOut);
    chk("base", 16'h1000, baseOut);
    chk("flags", 16'h0000, 16'({zeroFlag, overflowFlag}));
    $display("t_repeat finished");
  endtask
  task automatic t_exhaust();
    // zero entries, base near top so the sum wraps
    {i_mem.mem[16'hff80], i_mem.mem[16'hffc0], i_mem.mem[16'h0000]} = 24'h000000;
    run(STT_SCAN_DECREMENT_REPEAT_OP, 16'h4002, 16'hff80, 16'h0002, 1'b0, 1'b0);
    chk("count", 16'h0000, countOut);
    chk("flags", 16'h0003, 16'({zeroFlag, overflowFlag}));
    chk("cycles", 16'd40, 16'(cyc));
    chk("writes", 16'h0000, 16'(i_mem.nWr));
    $display("t_exhaust finished");
  endtask
  task automatic t_intr();
    run(STT_TRANSLATE_INCREMENT_REPEAT_OP, 16'h4002, 16'h1000, 16'h0002, 1'b1, 1'b0);
    chk("intTaken", 16'h0001, 16'(intTaken));
    chk("savedPc", 16'h0abc, savedPc);
    chk("ptr", 16'h4003, ptrOut);
    chk("count", 16'h0001, countOut);
    chk("cycles", 16'd33, 16'(cyc));
    chk("byte", 16'h0000, 16'(i_mem.mem[16'h4002]));
    $display("t_intr finished");
  endtask
  initial begin
    repeat (6) @(negedge clk_sys);
    reset_n = 1'b1;
    t_single();
    t_repeat();
    t_exhaust();
    t_intr();
    end_sim();
  end
endmodule
